/* verilog/rf_serial_control_port.sv */
// Purpose: event-triggered 3-wire serial downloader with AXI4-Lite registers
// Assumes: frame timer strobes are one-cycle pulses on aclk; data pins are async
// Notes:   all state sits in one packed struct registered once per clock
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module rf_serial_control_port
  import rf_serial_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              frame_valid_pulse,
  input  wire logic [15:0]       timer_strobe_event,
  output logic                   serial_clock_out,
  output logic                   serial_data_out,
  output logic                   serial_data_oe_n,
  input  wire logic              serial_data_in,
  input  wire logic              gpio_read_in,
  output logic                   device0_select,
  output logic                   device1_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic                    aw_pend;   // write address held
    logic [ADDR_W-1:0]       aw_addr;
    logic                    w_pend;    // write data held
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [15:0]             ctrl;      // serial_control
    logic [15:0]             enable;    // event_enable
    logic [15:0]             io_mode;   // pin_io_mode
    logic [15:0]             sw_out;    // software_pin_out
    logic [26:0][15:0]       wb_ctl;    // write buffer, control words
    logic [26:0][31:0]       wb_dat;    // write buffer, payloads
    logic [26:0][15:0]       ac_ctl;    // active buffer, control words
    logic [26:0][31:0]       ac_dat;    // active buffer, payloads
    logic                    imm_req;   // one-cycle immediate trigger
    seq_e                    seq;
    logic [4:0]              code;      // event being served
    logic [4:0]              idx;       // pair under scan
    logic [31:0]             shreg;     // word being shifted
    logic [4:0]              bitn;      // bit now on the wire
    logic [4:0]              cnt;       // phase cycle counter
    logic                    target;    // select of current word
    logic                    d_s1;      // data pin synchroniser
    logic                    d_s2;
    logic                    g_s1;      // gpio pin synchroniser
    logic                    g_s2;
    logic                    pin_sclk;
    logic                    pin_data;
    logic                    pin_oe_n;
    logic                    pin_cs0;
    logic                    pin_cs1;
  } state_s;

  state_s s;        // registered state
  state_s next_s;   // next state

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // pair index of a pair address: (addr - 4) / 8
  function automatic logic [4:0] pair_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - PAIR_BASE;
    return d[7:3];
  endfunction : pair_idx

  function automatic logic is_pair(input logic [ADDR_W-1:0] a);
    return (a >= OFF_PAIR_LO) && (a <= OFF_PAIR_HI) && (a[1:0] == 2'b00);
  endfunction : is_pair

  // last cycle count of one sclk phase for the rate field
  function automatic logic [4:0] phase_last(input logic [1:0] rate);
    unique case (rate)
      2'd0: return 5'(PHASE_R0 - 1);
      2'd1: return 5'(PHASE_R1 - 1);
      2'd2: return 5'(PHASE_R2 - 1);
      2'd3: return 5'(PHASE_R3 - 1);
    endcase
  endfunction : phase_last

  logic        sw_mode;    // software owns the pins
  logic [15:0] hit;        // enabled strobes this cycle
  logic [4:0]  hit_code;   // lowest enabled strobe
  logic        long_sel;   // long pulse for current target
  logic        phase_end;  // last cycle of a phase
  logic        advance;    // current word finished

  assign sw_mode = s.io_mode[IO_SW_MODE];

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic [4:0]        n;
    a        = '0;
    n        = '0;
    next_s   = s;
    advance  = 1'b0;
    hit_code = '0;
    next_s.imm_req = 1'b0;

    // pin synchronisers
    next_s.d_s1 = serial_data_in;
    next_s.d_s2 = s.d_s1;
    next_s.g_s1 = gpio_read_in;
    next_s.g_s2 = s.g_s1;

    // buffer transfer on frame valid
    if (frame_valid_pulse) begin
      next_s.ac_ctl = s.wb_ctl;
      next_s.ac_dat = s.wb_dat;
    end

    // write channel: address and data are taken in either order
    if (awvalid && awready) begin
      next_s.aw_pend = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_pend = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_pend && s.w_pend) begin
      a              = s.aw_addr;
      next_s.aw_pend = 1'b0;
      next_s.w_pend  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = 2'b00;
      if (a == OFF_CTRL) begin
        next_s.ctrl    = 16'(merge({16'h0000, s.ctrl}, s.w_data, s.w_strb)) & CTRL_MASK;
        next_s.imm_req = s.w_data[CTRL_IMM] & s.w_strb[0];
      end else if (a == OFF_ENABLE) begin
        next_s.enable  = 16'(merge({16'h0000, s.enable}, s.w_data, s.w_strb));
      end else if (a == OFF_IO_MODE) begin
        next_s.io_mode = 16'(merge({16'h0000, s.io_mode}, s.w_data, s.w_strb)) & IO_MASK;
      end else if (a == OFF_SW_OUT) begin
        next_s.sw_out  = 16'(merge({16'h0000, s.sw_out}, s.w_data, s.w_strb)) & SW_OUT_MASK;
      end else if (is_pair(a)) begin
        n = pair_idx(a);
        if (a[2]) begin
          // control word lands in the active or the write buffer
          if (s.ctrl[CTRL_DIRECT]) begin
            next_s.ac_ctl[n] = 16'(merge({16'h0000, s.ac_ctl[n]}, s.w_data, s.w_strb))
                               & WCTL_MASK;
          end else begin
            next_s.wb_ctl[n] = 16'(merge({16'h0000, s.wb_ctl[n]}, s.w_data, s.w_strb))
                               & WCTL_MASK;
          end
        end else if (s.ctrl[CTRL_DIRECT]) begin
          next_s.ac_dat[n] = merge(s.ac_dat[n], s.w_data, s.w_strb);
        end else begin
          next_s.wb_dat[n] = merge(s.wb_dat[n], s.w_data, s.w_strb);
        end
      end else begin
        next_s.bresp = 2'b10;  // unmapped or read-only
      end
    end

    // frame valid re-enables every event; it wins over a clearing write
    if (frame_valid_pulse) begin
      next_s.enable = ENABLE_RESET;
    end

    // read channel: answer one cycle after the address is taken
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = 2'b00;
      next_s.rdata  = '0;
      n             = pair_idx(araddr);
      if (araddr == OFF_CTRL) begin
        next_s.rdata[15:0] = s.ctrl;
      end else if (araddr == OFF_ENABLE) begin
        next_s.rdata[15:0] = s.enable;
      end else if (araddr == OFF_IO_MODE) begin
        next_s.rdata[15:0] = s.io_mode;
      end else if (araddr == OFF_SW_OUT) begin
        next_s.rdata[15:0] = s.sw_out;
      end else if (araddr == OFF_SW_IN) begin
        // read-back source: gpio pin in four-wire mode, data pin otherwise
        next_s.rdata[0] = s.io_mode[IO_FOUR_WIRE] ? s.g_s2 : s.d_s2;
      end else if (is_pair(araddr)) begin
        // reads follow the buffer that writes go to
        if (araddr[2]) begin
          next_s.rdata[15:0] = s.ctrl[CTRL_DIRECT] ? s.ac_ctl[n] : s.wb_ctl[n];
        end else begin
          next_s.rdata = s.ctrl[CTRL_DIRECT] ? s.ac_dat[n] : s.wb_dat[n];
        end
      end else begin
        next_s.rresp = 2'b10;
      end
    end

    // lowest enabled strobe this cycle
    for (int i = 15; i >= 0; i--) begin
      if (hit[i]) begin
        hit_code = 5'(i);
      end
    end

    // download sequencer
    unique case (s.seq)
      ST_IDLE: begin
        // events other than strobes 0-15 and the immediate code never start
        if (|hit) begin
          next_s.code = hit_code;
          next_s.idx  = '0;
          next_s.seq  = ST_SCAN;
        end else if (s.imm_req) begin
          next_s.code = CODE_IMM;
          next_s.idx  = '0;
          next_s.seq  = ST_SCAN;
        end
      end
      ST_SCAN: begin
        // one pair per cycle, lowest address first
        if (s.ac_ctl[s.idx][4:0] == s.code) begin
          next_s.shreg  = s.ac_dat[s.idx];
          next_s.bitn   = s.ac_ctl[s.idx][WCTL_LEN_LO +: 5];
          next_s.target = s.ac_ctl[s.idx][WCTL_TARGET];
          next_s.cnt    = '0;
          next_s.seq    = (s.ac_ctl[s.idx][WCTL_TARGET] ? !s.ctrl[CTRL_LEN1]
                                                         : !s.ctrl[CTRL_LEN0])
                          ? ST_LEAD : ST_LOW;
        end else begin
          advance = 1'b1;
        end
      end
      ST_LEAD: begin
        if (phase_end) begin
          next_s.cnt = '0;
          next_s.seq = ST_LOW;
        end else begin
          next_s.cnt = s.cnt + 5'd1;
        end
      end
      ST_LOW: begin
        if (phase_end) begin
          next_s.cnt = '0;
          next_s.seq = ST_HIGH;
        end else begin
          next_s.cnt = s.cnt + 5'd1;
        end
      end
      ST_HIGH: begin
        if (!phase_end) begin
          next_s.cnt = s.cnt + 5'd1;
        end else if (s.bitn != 5'd0) begin
          next_s.cnt  = '0;
          next_s.bitn = s.bitn - 5'd1;
          next_s.seq  = ST_LOW;
        end else if (long_sel) begin
          next_s.cnt = '0;
          next_s.seq = ST_TAIL;
        end else begin
          advance = 1'b1;
        end
      end
      ST_TAIL: begin
        if (phase_end) begin
          advance = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 5'd1;
        end
      end
    endcase

    // move on to the next pair; every word with the code is sent
    if (advance) begin
      next_s.cnt = '0;
      if (s.idx == LAST_PAIR) begin
        next_s.seq = ST_IDLE;
      end else begin
        next_s.idx = s.idx + 5'd1;
        next_s.seq = ST_SCAN;
      end
    end

    // pin drivers, registered
    next_s.pin_oe_n = !s.io_mode[IO_DATA_OUT];
    if (sw_mode) begin
      next_s.pin_sclk = s.sw_out[SW_CLK];
      next_s.pin_data = s.sw_out[SW_DATA];
      next_s.pin_cs0  = s.io_mode[IO_SW_SEL] ? s.ctrl[CTRL_POL0] : s.sw_out[SW_CS];
      next_s.pin_cs1  = s.io_mode[IO_SW_SEL] ? s.sw_out[SW_CS] : s.ctrl[CTRL_POL1];
    end else begin
      next_s.pin_sclk = (s.seq == ST_HIGH) ^ s.ctrl[CTRL_CLK_INV];
      next_s.pin_data = s.shreg[s.bitn];
      next_s.pin_cs0  = (s.seq inside {ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL} && !s.target)
                        ^ s.ctrl[CTRL_POL0];
      next_s.pin_cs1  = (s.seq inside {ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL} && s.target)
                        ^ s.ctrl[CTRL_POL1];
    end
  end

  // strobes pass only where enabled; the immediate bit leaves enables alone
  assign hit       = timer_strobe_event & s.enable;
  assign phase_end = (s.cnt == phase_last(s.ctrl[CTRL_RATE_LO +: 2]));
  assign long_sel  = s.target ? !s.ctrl[CTRL_LEN1] : !s.ctrl[CTRL_LEN0];

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.enable  <= ENABLE_RESET;
      s.io_mode <= IO_RESET;
      s.pin_oe_n <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign awready          = !s.aw_pend && !s.bvalid;
  assign wready           = !s.w_pend && !s.bvalid;
  assign bvalid           = s.bvalid;
  assign bresp            = s.bresp;
  assign arready          = !s.rvalid;
  assign rvalid           = s.rvalid;
  assign rdata            = s.rdata;
  assign rresp            = s.rresp;
  assign serial_clock_out = s.pin_sclk;
  assign serial_data_out  = s.pin_data;
  assign serial_data_oe_n = s.pin_oe_n;
  assign device0_select   = s.pin_cs0;
  assign device1_select   = s.pin_cs1;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sclk_idle: assert property ((s.seq == ST_IDLE) && !sw_mode && $stable(s.ctrl)
    |=> serial_clock_out == $past(s.ctrl[CTRL_CLK_INV]))
    else $error("sclk not at idle level");
  a_phase_len: assert property ($rose(s.seq == ST_LOW) && s.ctrl[2:1] == 2'd0
    && !frame_valid_pulse |-> (s.seq == ST_LOW)[*8] ##1 (s.seq == ST_HIGH))
    else $error("low phase not eight cycles at fastest rate");
  a_imm_start: assert property ((s.seq == ST_IDLE) && s.imm_req && (hit == 16'h0000)
    |=> (s.seq == ST_SCAN) && (s.code == CODE_IMM) && (s.idx == 5'd0))
    else $error("immediate trigger did not start");
  a_busy_drop: assert property ((s.seq != ST_IDLE) && (s.seq != ST_SCAN || !advance)
    && (|hit) |=> $stable(s.code))
    else $error("event taken while busy");
  a_frame_enable: assert property (frame_valid_pulse |=> s.enable == ENABLE_RESET)
    else $error("enables not set by frame valid");
  a_gate_off: assert property ((s.seq == ST_IDLE) && (hit == 16'h0000) && !s.imm_req
    |=> s.seq == ST_IDLE)
    else $error("download without enabled event");
  a_sw_pins: assert property (sw_mode |=> serial_clock_out == $past(s.sw_out[SW_CLK])
    && serial_data_out == $past(s.sw_out[SW_DATA]))
    else $error("software pins not followed");
  a_data_dir: assert property (1'b1
    |=> serial_data_oe_n == !$past(s.io_mode[IO_DATA_OUT]))
    else $error("data direction wrong");
  a_bit_order: assert property ((s.seq == ST_HIGH) && !sw_mode
    |=> serial_data_out == $past(s.shreg[s.bitn]))
    else $error("wrong bit on data pin");
  a_sel_active: assert property ((s.seq == ST_LOW) && !sw_mode && !s.target
    && $stable(s.ctrl) |=> device0_select == !$past(s.ctrl[CTRL_POL0]))
    else $error("select 0 not active during word");

endmodule : rf_serial_control_port

`default_nettype wire

/* verilog/rf_serial_pkg.sv */
// Purpose: shared constants and types of the rf serial control port
// Assumes: 100 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   offsets are byte addresses; derived counts come from the rates below
`default_nettype none

package rf_serial_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int               ADDR_W       = 12;             // byte address width
  localparam logic [11:0]      OFF_CTRL     = 12'h000;        // serial_control
  localparam logic [11:0]      OFF_PAIR_LO  = 12'h004;        // word0_control
  localparam logic [11:0]      OFF_PAIR_HI  = 12'h0d8;        // last word payload
  localparam logic [11:0]      PAIR_BASE    = 12'h004;        // pair n at base + 8n
  localparam logic [11:0]      OFF_ENABLE   = 12'h190;        // event_enable
  localparam logic [11:0]      OFF_IO_MODE  = 12'h194;        // pin_io_mode
  localparam logic [11:0]      OFF_SW_OUT   = 12'h198;        // software_pin_out
  localparam logic [11:0]      OFF_SW_IN    = 12'h19c;        // software_pin_in
  localparam int               NUM_PAIRS    = 27;             // control/payload pairs
  localparam logic [4:0]       LAST_PAIR    = 5'h1a;          // index of pair 26

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int               CTRL_CLK_INV = 0;              // sclk_invert
  localparam int               CTRL_RATE_LO = 1;              // bit_rate_select[1:0]
  localparam int               CTRL_IMM     = 3;              // immediate_trigger (wo)
  localparam int               CTRL_LEN0    = 4;              // select_pulse_short, dev 0
  localparam int               CTRL_POL0    = 5;              // select_invert, dev 0
  localparam int               CTRL_LEN1    = 6;              // select_pulse_short, dev 1
  localparam int               CTRL_POL1    = 7;              // select_invert, dev 1
  localparam int               CTRL_DIRECT  = 8;              // direct_active_write
  localparam logic [15:0]      CTRL_MASK    = 16'h01f7;       // stored bits
  localparam int               WCTL_LEN_LO  = 8;              // length field [12:8]
  localparam int               WCTL_TARGET  = 15;             // target_device_select
  localparam logic [15:0]      WCTL_MASK    = 16'h9f1f;       // stored bits
  localparam int               IO_SW_MODE   = 0;              // software drives pins
  localparam int               IO_DATA_OUT  = 1;              // data_pin_output
  localparam int               IO_FOUR_WIRE = 2;              // read back from gpio pin
  localparam int               IO_SW_SEL    = 3;              // sw_select_choice
  localparam logic [15:0]      IO_MASK      = 16'h000f;
  localparam int               SW_CLK       = 0;
  localparam int               SW_CS        = 1;
  localparam int               SW_DATA      = 2;
  localparam logic [15:0]      SW_OUT_MASK  = 16'h0007;
  localparam logic [4:0]       CODE_IMM     = 5'h1f;          // immediate download code

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0]      ENABLE_RESET = 16'hffff;
  localparam logic [15:0]      IO_RESET     = 16'h0002;       // data pin is an output

  ////////////////////////////////////////////////////////////////////////////////
  // bit rate: one sclk phase lasts ceil(clk * div / (2 * base)) cycles
  localparam int               CLK_KHZ      = 100000;         // aclk rate
  localparam int               BASE_KHZ     = 13000;          // serial base rate
  localparam int               PHASE_R0     = (CLK_KHZ * 2 + 2 * BASE_KHZ - 1) / (2 * BASE_KHZ);
  localparam int               PHASE_R1     = (CLK_KHZ * 4 + 2 * BASE_KHZ - 1) / (2 * BASE_KHZ);
  localparam int               PHASE_R2     = (CLK_KHZ * 6 + 2 * BASE_KHZ - 1) / (2 * BASE_KHZ);
  localparam int               PHASE_R3     = (CLK_KHZ * 8 + 2 * BASE_KHZ - 1) / (2 * BASE_KHZ);

  // download sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL} seq_e;

endpackage : rf_serial_pkg

`default_nettype wire

/* sim/rf_chip_model.sv */
// Purpose: rf chip that listens on one select line of the serial link
// Assumes: true sclk and select sense
// Notes:   the word restarts at each select
`default_nettype none
module rf_chip_model (
  input  wire logic        sclk,
  input  wire logic        sel,
  input  wire logic        sdata,
  output logic [31:0]      word = '0,
  output logic [5:0]       bits = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // a new select starts a fresh word
  always @(posedge sel) begin
    word = '0;
    bits = '0;
  end
  // sample on the active edge while selected
  always @(posedge sclk) if (sel) begin
    word = {word[30:0], sdata};
    bits = bits + 6'h01;
  end
endmodule : rf_chip_model
`default_nettype wire

/* sim/rf_serial_control_port_tb.sv */
// Purpose: register and serial link tests of the rf serial control port
// Assumes: pairs loaded through the write buffer, later patched in direct mode
// Notes:   a released data pin drifts to the inverse of its last drive
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t ns: got %h", $time, g); end end
module rf_serial_control_port_tb import rf_serial_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, frame_valid_pulse = 0, gpio_read_in = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_v, word0, word1;
  logic [15:0] timer_strobe_event = '0;
  logic        awready, wready, bvalid, arready, rvalid, serial_clock_out, serial_data_out;
  logic        serial_data_oe_n, device0_select, device1_select;
  logic [1:0]  bresp, rresp, rr;
  logic [5:0]  bits0, bits1;
  int          err_total = 0, checked = 0, cyc = 0;
  // released pin shows the inverse of what was last driven
  wire logic   serial_data_in = serial_data_oe_n ? !serial_data_out : serial_data_out;
  rf_serial_control_port i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .frame_valid_pulse, .timer_strobe_event,
    .serial_clock_out, .serial_data_out, .serial_data_oe_n, .serial_data_in, .gpio_read_in,
    .device0_select, .device1_select);
  rf_chip_model m0 (.sclk(serial_clock_out), .sel(device0_select), .sdata(serial_data_out),
    .word(word0), .bits(bits0));
  rf_chip_model m1 (.sclk(serial_clock_out), .sel(device1_select), .sdata(serial_data_out),
    .word(word1), .bits(bits1));
  ////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;
  // cycle ceiling cuts a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // axi write: each channel released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (awvalid || wvalid || bready) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      @(posedge aclk);
    end
  endtask : wr
  // axi read: data and response taken at the rvalid edge
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arvalid || rready) begin
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd_v = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
      @(posedge aclk);
    end
  endtask : rd
  task automatic pulse(input logic [15:0] s);
    timer_strobe_event <= s;
    @(posedge aclk);
    timer_strobe_event <= '0;
  endtask : pulse
  task automatic frame;
    frame_valid_pulse <= 1'b1;
    @(posedge aclk);
    frame_valid_pulse <= 1'b0;
  endtask : frame
  // events are spaced: wait until both selects stay idle for 40 cycles
  task automatic quiet;
    int k, q;
    q = 0;
    for (k = 0; k < 3000 && q < 40; k++) begin
      @(posedge aclk);
      q = (device0_select || device1_select) ? 0 : q + 1;
    end
  endtask : quiet
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_ENABLE); `CHK(rd_v, 32'h0000_ffff)
    rd(OFF_IO_MODE); `CHK(rd_v, 32'h0000_0002)
    rd(OFF_SW_OUT); `CHK(rd_v, 32'h0000_0000)
    rd(12'h1a0); `CHK(rr, 2'b10)
    // pairs go to the write buffer and become live on frame valid
    wr(PAIR_BASE, 32'h0000_0703);
    wr(12'h008, 32'h0000_01a5);
    wr(12'h00c, 32'h0000_831f);
    wr(12'h010, 32'h0000_0009);
    wr(12'h014, 32'h0000_0010);
    wr(12'h018, 32'h0000_0001);
    rd(12'h00c); `CHK(rd_v, 32'h0000_831f)
    wr(OFF_ENABLE, 32'h0000_fff7); frame;
    rd(OFF_ENABLE); `CHK(rd_v, 32'h0000_ffff)
    wr(OFF_ENABLE, 32'h0000_fff7);
    pulse(16'h0008); quiet; `CHK(bits0, 6'h00)
    // a second event in mid-word must be dropped
    frame; pulse(16'h0008); repeat (20) @(posedge aclk); pulse(16'h0001); quiet;
    `CHK(word0, 32'h0000_00a5)
    `CHK(bits0, 6'h08)
    wr(OFF_CTRL, 32'h0000_0108); quiet; `CHK(word1, 32'h0000_0009)
    `CHK(bits1, 6'h04)
    `CHK(bits0, 6'h08)
    // direct patch, slowest rate and short select
    wr(12'h008, 32'h0000_0033); wr(OFF_CTRL, 32'h0000_0116);
    pulse(16'h0008); quiet; `CHK(word0, 32'h0000_0033)
    wr(OFF_CTRL, 32'h0000_0121); repeat (3) @(posedge aclk);
    `CHK({serial_clock_out, device0_select}, 2'b11)
    wr(OFF_IO_MODE, 32'h0000_0001); wr(OFF_SW_OUT, 32'h0000_0007); repeat (3) @(posedge aclk);
    `CHK({serial_clock_out, device0_select, serial_data_out}, 3'b111)
    wr(OFF_IO_MODE, 32'h0000_000d); gpio_read_in <= 1'b1; repeat (4) @(posedge aclk);
    `CHK({device1_select, serial_data_oe_n}, 2'b11)
    rd(OFF_SW_IN); `CHK(rd_v, 32'h0000_0001)
    // three-wire read back: released data pin reads low, gpio stays high
    wr(OFF_IO_MODE, 32'h0000_0009); repeat (2) @(posedge aclk);
    rd(OFF_SW_IN); `CHK(rd_v, 32'h0000_0000)
    wrap_up;
  end
endmodule : rf_serial_control_port_tb
`default_nettype wire
